/* File: hs_central_codec.sv */
// Central transceiver end: handshake states, capability list and mode select.
// Assumes the link carries whole parameter octets; modulation sits downstream.
`timescale 1ns/1ps

module hs_central_codec
  import hs_codec_pkg::*;
#(
  parameter int unsigned SILENT_LEN = SILENT_CYCLES
) (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic arst_n_in,
  // Network control
  input wire logic net_start_in,
  input wire logic loss_of_signal_in,
  input wire logic init_error_in,
  // Local capabilities
  input wire logic [5:0] cap_flags_in,
  input wire logic [5:0] dft_mult_in,
  input wire logic [9:0] ce_len_in,
  input wire logic [1:0] frame_bits_in,
  // Link
  hs_link_if.central link,
  // Status
  output logic silent_out,
  output logic busy_out,
  output logic quiet_out,
  output logic training_out,
  output logic [5:0] sel_ns_out,
  output logic [15:0] dft_points_out,
  output logic [9:0] ce_len_out,
  output logic dpsk_bit_out
);

  // ****************************************
  // State
  // ****************************************
  typedef enum logic [5:0] {
    ST_SILENT = 6'b000001,
    ST_SEND_CL = 6'b000010,
    ST_WAIT_CLR = 6'b000100,
    ST_SEND_MS = 6'b001000,
    ST_QUIET = 6'b010000,
    ST_TRAIN = 6'b100000
  } cstate_t;

  typedef struct packed {
    cstate_t st;
    logic [2:0] idx;
    msg_type_t tx_type;
    logic [5:0] peer_ns;
    logic [5:0] sel_ns;
    logic [5:0] dft;
    logic [9:0] ce;
    logic [15:0] quiet_cnt;
    logic dpsk;
  } cstate_all_t;

  cstate_all_t state_reg;
  cstate_all_t state_next;
  logic [5:0] cl_ns;
  logic [5:0] ms_ns;
  logic [7:0] tx_octet;

  always_comb begin
    cl_ns = cap_flags_in & NS_MASK;
    if (!cl_ns[BIT_STM] && !cl_ns[BIT_ATM]) begin
      cl_ns[BIT_ATM] = 1'b1;
    end
  end

  // Pick at most one band direction, exactly one transport
  always_comb begin
    ms_ns = cl_ns & state_reg.peer_ns;
    if (ms_ns[BIT_UP_LOWER] && ms_ns[BIT_DN_LOWER]) begin
      ms_ns[BIT_UP_LOWER] = 1'b0;
    end
    if (ms_ns[BIT_STM]) begin
      ms_ns[BIT_ATM] = 1'b0;
    end else if (!ms_ns[BIT_ATM]) begin
      ms_ns[BIT_ATM] = 1'b1;
    end
  end

  // Octet builder for outgoing messages
  // Framing bits 8,7 passed through
  always_comb begin
    tx_octet = 8'h00;
    unique case (state_reg.idx)
      IDX_L1: tx_octet = {frame_bits_in, L1_LINE_MODE[5:0]};
      IDX_NS: tx_octet = {frame_bits_in,
                          (state_reg.tx_type == MSG_MS) ? ms_ns : cl_ns};
      IDX_SEL: tx_octet = {frame_bits_in, SEL_MASK};
      IDX_DFT: tx_octet = {frame_bits_in, dft_mult_in};
      IDX_CE1: tx_octet = {frame_bits_in, 2'b00, ce_len_in[9:6]};
      IDX_CE2: tx_octet = {frame_bits_in, ce_len_in[5:0]};
      default: tx_octet = 8'h00;
    endcase
  end

  // Next state
  always_comb begin
    state_next = state_reg;
    unique case (state_reg.st)
      ST_SILENT: begin
        if (net_start_in) begin
          state_next.st = ST_SEND_CL;
          state_next.idx = IDX_L1;
          state_next.tx_type = MSG_CL;
        end
      end
      ST_SEND_CL, ST_SEND_MS: begin
        if (link.c2r_ready) begin
          state_next.dpsk = state_reg.dpsk ^ tx_octet[0];
          if (state_reg.idx == IDX_LAST) begin
            state_next.idx = IDX_L1;
            state_next.st = (state_reg.st == ST_SEND_CL) ? ST_WAIT_CLR : ST_QUIET;
            state_next.quiet_cnt = '0;
            if (state_reg.st == ST_SEND_MS) begin
              state_next.sel_ns = ms_ns;
              state_next.dft = dft_mult_in;
              state_next.ce = ce_len_in;
            end
          end else begin
            state_next.idx = state_reg.idx + 3'h1;
          end
        end
      end
      ST_WAIT_CLR: begin
        if (link.r2c_valid && link.r2c_type == MSG_CLR) begin
          if (state_reg.idx == IDX_NS) begin
            state_next.peer_ns = link.r2c_octet[5:0];
          end
          state_next.idx = link.r2c_last ? IDX_L1 : state_reg.idx + 3'h1;
          if (link.r2c_last) begin
            state_next.st = ST_SEND_MS;
            state_next.tx_type = MSG_MS;
          end
        end
      end
      ST_QUIET: begin
        if (state_reg.quiet_cnt == 16'(SILENT_LEN - 1)) begin
          state_next.st = ST_TRAIN;
        end else begin
          state_next.quiet_cnt = state_reg.quiet_cnt + 16'h0001;
        end
      end
      ST_TRAIN: state_next.st = ST_TRAIN;
      default: state_next.st = ST_SILENT;
    endcase
    // Loss or error returns to silence
    if (loss_of_signal_in || init_error_in) begin
      state_next.st = ST_SILENT;
      state_next.idx = IDX_L1;
    end
  end

  // Register
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state_reg <= '{st: ST_SILENT, idx: IDX_L1, tx_type: MSG_CL, peer_ns: NO_PARAMS,
                     sel_ns: NO_PARAMS, dft: DEF_DFT_MULT, ce: DEF_CE_LEN,
                     quiet_cnt: 16'h0000, dpsk: 1'b0};
    end else begin
      state_reg <= state_next;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  // Duplex message octets
  assign link.c2r_valid = (state_reg.st == ST_SEND_CL) || (state_reg.st == ST_SEND_MS);
  assign link.c2r_octet = tx_octet;
  assign link.c2r_last = (state_reg.idx == IDX_LAST);
  assign link.c2r_type = state_reg.tx_type;
  assign link.r2c_ready = (state_reg.st == ST_WAIT_CLR);
  assign silent_out = (state_reg.st == ST_SILENT);
  assign busy_out = link.c2r_valid || link.r2c_ready;
  assign quiet_out = (state_reg.st == ST_QUIET);
  assign training_out = (state_reg.st == ST_TRAIN);
  assign sel_ns_out = state_reg.sel_ns;
  assign dft_points_out = {2'b00, state_reg.dft, 8'h00};
  assign ce_len_out = state_reg.ce;
  // One differential bit for all carriers
  assign dpsk_bit_out = state_reg.dpsk;

endmodule : hs_central_codec

/* File: hs_codec_pkg.sv */
// Constants and types shared by both ends of the handshake capability field codec.
// Assumes the framing layer around it delivers and accepts whole octets.
package hs_codec_pkg;

  // ****************************************
  // Octet field positions (bit n of the text is index n-1)
  // ****************************************
  localparam int unsigned BIT_UP_LOWER = 0;
  localparam int unsigned BIT_DN_LOWER = 1;
  localparam int unsigned BIT_NS_RSVD = 2;
  localparam int unsigned BIT_STM = 3;
  localparam int unsigned BIT_ATM = 4;
  localparam int unsigned BIT_EOC_CLEAR = 5;
  localparam int unsigned BIT_SUBCHAN = 0;
  localparam int unsigned BIT_DFT_SIZE = 3;
  localparam int unsigned BIT_CE_LEN = 4;
  localparam logic [5:0] SEL_MASK = 6'h18;
  localparam logic [5:0] NS_MASK = 6'h3B;
  localparam logic [5:0] NO_PARAMS = 6'h00;
  localparam logic [5:0] DEF_DFT_MULT = 6'h08;
  localparam logic [9:0] DEF_CE_LEN = 10'h040;
  localparam int unsigned DFT_POINTS_SHIFT = 8;
  localparam int unsigned SILENT_CYCLES = 16;

  // ****************************************
  // Message types and octet index
  // ****************************************
  typedef enum logic [1:0] {
    MSG_CL = 2'h0,
    MSG_CLR = 2'h1,
    MSG_MS = 2'h2
  } msg_type_t;

  localparam int unsigned NUM_OCTETS = 6;
  localparam logic [2:0] IDX_L1 = 3'h0;
  localparam logic [2:0] IDX_NS = 3'h1;
  localparam logic [2:0] IDX_SEL = 3'h2;
  localparam logic [2:0] IDX_DFT = 3'h3;
  localparam logic [2:0] IDX_CE1 = 3'h4;
  localparam logic [2:0] IDX_CE2 = 3'h5;
  localparam logic [2:0] IDX_LAST = 3'h5;
  localparam logic [7:0] L1_LINE_MODE = 8'h01;

endpackage : hs_codec_pkg

/* File: hs_link_if.sv */
// Octet stream between central and remote handshake codecs.
// Assumes one clock; valid/ready handshake per octet.
`timescale 1ns/1ps
interface hs_link_if;
  import hs_codec_pkg::*;
  // Central to remote
  logic c2r_valid;
  logic c2r_ready;
  logic [7:0] c2r_octet;
  logic c2r_last;
  msg_type_t c2r_type;
  // Remote to central
  logic r2c_valid;
  logic r2c_ready;
  logic [7:0] r2c_octet;
  logic r2c_last;
  msg_type_t r2c_type;

  modport central (output c2r_valid, c2r_octet, c2r_last, c2r_type, r2c_ready,
                   input c2r_ready, r2c_valid, r2c_octet, r2c_last, r2c_type);
  modport remote (input c2r_valid, c2r_octet, c2r_last, c2r_type, r2c_ready,
                  output c2r_ready, r2c_valid, r2c_octet, r2c_last, r2c_type);
endinterface : hs_link_if

/* File: hs_remote_codec.sv */
// Remote transceiver end: parses central messages, answers with a request list.
// Assumes central sends capability list first, then mode select.
`timescale 1ns/1ps
module hs_remote_codec
  import hs_codec_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic arst_n_in,
  // Local capabilities
  input wire logic [5:0] cap_flags_in,
  input wire logic [5:0] dft_mult_in,
  input wire logic [9:0] ce_len_in,
  input wire logic [1:0] frame_bits_in,
  // Link
  hs_link_if.remote link,
  // Results
  output logic done_out,
  output logic [5:0] sel_ns_out,
  output logic [5:0] dft_mult_out,
  output logic [9:0] ce_len_out,
  output logic [1:0] frame_bits_out
);

  typedef enum logic [2:0] {
    RS_LISTEN = 3'b001,
    RS_SEND = 3'b010,
    RS_DONE = 3'b100
  } rstate_t;

  typedef struct packed {
    rstate_t st;
    logic [2:0] idx;
    logic [5:0] ns;
    logic [5:0] dft;
    logic [9:0] ce;
    logic [1:0] fb;
  } rstate_all_t;

  rstate_all_t state_reg;
  rstate_all_t state_next;
  logic [7:0] tx_octet;

  // Request list octets
  always_comb begin
    tx_octet = 8'h00;
    unique case (state_reg.idx)
      IDX_L1: tx_octet = {frame_bits_in, L1_LINE_MODE[5:0]};
      IDX_NS: tx_octet = {frame_bits_in, cap_flags_in & NS_MASK};
      IDX_SEL: tx_octet = {frame_bits_in, SEL_MASK};
      IDX_DFT: tx_octet = {frame_bits_in, dft_mult_in};
      IDX_CE1: tx_octet = {frame_bits_in, 2'b00, ce_len_in[9:6]};
      IDX_CE2: tx_octet = {frame_bits_in, ce_len_in[5:0]};
      default: tx_octet = 8'h00;
    endcase
  end

  // Parse incoming and sequence reply
  always_comb begin
    state_next = state_reg;
    unique case (state_reg.st)
      RS_LISTEN: begin
        if (link.c2r_valid) begin
          state_next.fb = link.c2r_octet[7:6];
          if (link.c2r_type == MSG_MS) begin
            if (state_reg.idx == IDX_NS) state_next.ns = link.c2r_octet[5:0];
            if (state_reg.idx == IDX_DFT) state_next.dft = link.c2r_octet[5:0];
            if (state_reg.idx == IDX_CE1) state_next.ce[9:6] = link.c2r_octet[3:0];
            if (state_reg.idx == IDX_CE2) state_next.ce[5:0] = link.c2r_octet[5:0];
          end
          state_next.idx = link.c2r_last ? IDX_L1 : state_reg.idx + 3'h1;
          if (link.c2r_last) begin
            state_next.st = (link.c2r_type == MSG_MS) ? RS_DONE : RS_SEND;
          end
        end
      end
      RS_SEND: begin
        if (link.r2c_ready) begin
          state_next.idx = (state_reg.idx == IDX_LAST) ? IDX_L1 : state_reg.idx + 3'h1;
          if (state_reg.idx == IDX_LAST) state_next.st = RS_LISTEN;
        end
      end
      RS_DONE: state_next.st = RS_DONE;
      default: state_next.st = RS_LISTEN;
    endcase
  end

  // Register
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state_reg <= '{st: RS_LISTEN, idx: IDX_L1, ns: NO_PARAMS, dft: DEF_DFT_MULT,
                     ce: DEF_CE_LEN, fb: 2'b00};
    end else begin
      state_reg <= state_next;
    end
  end

  // Outputs
  assign link.c2r_ready = (state_reg.st == RS_LISTEN);
  assign link.r2c_valid = (state_reg.st == RS_SEND);
  assign link.r2c_octet = tx_octet;
  assign link.r2c_last = (state_reg.idx == IDX_LAST);
  assign link.r2c_type = MSG_CLR;
  assign done_out = (state_reg.st == RS_DONE);
  assign sel_ns_out = state_reg.ns;
  assign dft_mult_out = state_reg.dft;
  assign ce_len_out = state_reg.ce;
  assign frame_bits_out = state_reg.fb;

endmodule : hs_remote_codec

/* File: hs_codec_properties.sv */
// Checker for the central-to-remote octet stream of the link.
// Assumes it is instantiated beside the link interface, one clock.
`timescale 1ns/1ps
module hs_codec_properties
  import hs_codec_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic arst_n_in,
  // Central to remote
  input wire logic c2r_valid,
  input wire logic c2r_ready,
  input wire logic [7:0] c2r_octet,
  input wire logic c2r_last,
  input wire msg_type_t c2r_type,
  // Remote to central
  input wire logic r2c_valid,
  input wire logic r2c_ready,
  input wire logic r2c_last
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!arst_n_in);
  logic [2:0] idx_reg;
  logic [2:0] idx_next;
  logic c2r_take;

  // ****************************************
  // Octet index within a message
  // ****************************************
  assign c2r_take = c2r_valid & c2r_ready;
  always_comb begin
    idx_next = idx_reg;
    if (c2r_take) begin
      idx_next = c2r_last ? 3'h0 : idx_reg + 3'h1;
    end
  end
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      idx_reg <= 3'h0;
    end else begin
      idx_reg <= idx_next;
    end
  end

  // ****************************************
  // Properties
  // ****************************************
  property p_hold;
    c2r_valid && !c2r_ready |=> c2r_valid && $stable(c2r_octet);
  endproperty
  a_hold: assert property (p_hold)
    else $error("octet changed before ready");
  property p_level1;
    c2r_valid && idx_reg == IDX_L1 |-> c2r_octet[5:0] == L1_LINE_MODE[5:0];
  endproperty
  a_level1: assert property (p_level1)
    else $error("line mode bit missing");
  property p_rsvd;
    c2r_valid && idx_reg == IDX_NS |-> !c2r_octet[BIT_NS_RSVD];
  endproperty
  a_rsvd: assert property (p_rsvd)
    else $error("reserved flag set");
  property p_cl_tr;
    c2r_valid && idx_reg == IDX_NS && c2r_type == MSG_CL |-> c2r_octet[4:3] != 2'b00;
  endproperty
  a_cl_tr: assert property (p_cl_tr)
    else $error("list without transport");
  property p_ms_one;
    c2r_valid && idx_reg == IDX_NS && c2r_type == MSG_MS |-> ^c2r_octet[4:3] && !(&c2r_octet[1:0]);
  endproperty
  a_ms_one: assert property (p_ms_one)
    else $error("select not single");
  property p_sel;
    c2r_valid && idx_reg == IDX_SEL |-> c2r_octet[5:0] == SEL_MASK;
  endproperty
  a_sel: assert property (p_sel)
    else $error("bad select octet");
  property p_ce1;
    c2r_valid && idx_reg == IDX_CE1 |-> c2r_octet[5:4] == 2'b00;
  endproperty
  a_ce1: assert property (p_ce1)
    else $error("extension high bits not zero");
  property p_last;
    c2r_valid && c2r_last |-> idx_reg == IDX_LAST;
  endproperty
  a_last: assert property (p_last)
    else $error("message length wrong");
  c_cl: cover property (c2r_take && c2r_last && c2r_type == MSG_CL);
  c_ms: cover property (c2r_take && c2r_last && c2r_type == MSG_MS);
  c_clr: cover property (r2c_valid && r2c_ready && r2c_last);
endmodule : hs_codec_properties

/* File: testbench.sv */
// Self-checking bench joining both codec ends over one link.
// Assumes a 20 MHz clock; checker sits beside the link.
`timescale 1ns/1ps
module testbench;
  import hs_codec_pkg::*;
  localparam int unsigned SLEN = 4;
  logic clk_sys_in = 1'b0;
  logic arst_n_in = 1'b0;
  logic net_start = 1'b0;
  logic los = 1'b0;
  logic ierr = 1'b0;
  logic [5:0] c_cap = 6'h18;
  logic [5:0] r_cap = 6'h18;
  logic [5:0] dft = 6'h08;
  logic [9:0] ce = 10'h040;
  logic [1:0] c_fb = 2'h0;
  logic [1:0] r_fb = 2'h0;
  logic silent, busy, quiet, training, done, dpsk;
  logic [5:0] c_sel, r_sel, r_dft, exp_sel;
  logic [15:0] c_pts;
  logic [9:0] c_ce, r_ce;
  logic [1:0] r_fbo;
  int errors = 0;
  int checks = 0;
  int cycles = 0;
  int q;
  int n;
  int b;

  // ****************************************
  // Structure
  // ****************************************
  hs_link_if link ();
  hs_central_codec #(.SILENT_LEN(SLEN)) hs_central_codec_i (.clk_sys_in(clk_sys_in),
    .arst_n_in(arst_n_in), .net_start_in(net_start), .loss_of_signal_in(los),
    .init_error_in(ierr), .cap_flags_in(c_cap), .dft_mult_in(dft), .ce_len_in(ce),
    .frame_bits_in(c_fb), .link(link), .silent_out(silent), .busy_out(busy),
    .quiet_out(quiet), .training_out(training), .sel_ns_out(c_sel),
    .dft_points_out(c_pts), .ce_len_out(c_ce), .dpsk_bit_out(dpsk));
  hs_remote_codec hs_remote_codec_i (.clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in),
    .cap_flags_in(r_cap), .dft_mult_in(dft), .ce_len_in(ce), .frame_bits_in(r_fb),
    .link(link), .done_out(done), .sel_ns_out(r_sel), .dft_mult_out(r_dft),
    .ce_len_out(r_ce), .frame_bits_out(r_fbo));
  hs_codec_properties hs_codec_properties_i (.clk_sys_in(clk_sys_in),
    .arst_n_in(arst_n_in), .c2r_valid(link.c2r_valid), .c2r_ready(link.c2r_ready),
    .c2r_octet(link.c2r_octet), .c2r_last(link.c2r_last), .c2r_type(link.c2r_type),
    .r2c_valid(link.r2c_valid), .r2c_ready(link.r2c_ready), .r2c_last(link.r2c_last));

  // Clock and hang limit
  always #25 clk_sys_in = ~clk_sys_in;
  always @(posedge clk_sys_in) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      $display("ERROR %0t: timeout", $time);
      finish_test();
    end
  end

  // ****************************************
  // Tasks and model
  // ****************************************
  task automatic step();
    @(posedge clk_sys_in);
    #5;
  endtask : step
  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check
  task automatic finish_test();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : finish_test
  // Flags that the mode select should carry
  function automatic logic [5:0] ms_flags(input logic [5:0] c, input logic [5:0] r);
    logic [5:0] m;
    if (c[4:3] == 2'b00) c[BIT_ATM] = 1'b1;
    m = c & r & NS_MASK;
    if (m[1:0] == 2'b11) m[BIT_UP_LOWER] = 1'b0;
    if (m[4:3] == 2'b11) m[BIT_ATM] = 1'b0;
    if (m[4:3] == 2'b00) m[BIT_ATM] = 1'b1;
    return m;
  endfunction : ms_flags

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    void'($urandom(40984));
    repeat (3) @(posedge clk_sys_in);
    #5 arst_n_in = 1'b1;
    repeat (5) step();
    check(silent, 1'b1, "silent after reset");
    check(link.c2r_valid, 1'b0, "sent unasked");
    for (int t = 0; t < 8; t++) begin
      // Mid-run reset brings both ends back to their start
      arst_n_in = 1'b0;
      step();
      arst_n_in = 1'b1;
      step();
      check(silent, 1'b1, "silent after mid reset");
      check(done, 1'b0, "remote idle after reset");
      c_cap = 6'($urandom());
      r_cap = 6'($urandom());
      dft = 6'($urandom_range(1, 63));
      ce = 10'($urandom());
      c_fb = 2'($urandom());
      r_fb = 2'($urandom());
      exp_sel = ms_flags(c_cap, r_cap);
      net_start = 1'b1;
      step();
      net_start = 1'b0;
      q = 0;
      b = 0;
      n = 0;
      // Sample each cycle once, the first send cycle included
      while (training !== 1'b1 && n < 300) begin
        if (quiet === 1'b1) q++;
        if (busy === 1'b1) b++;
        step();
        n++;
      end
      check(done, 1'b1, "remote done");
      check(16'(q), 16'(SLEN), "quiet length");
      check(16'(b), 16'(3 * NUM_OCTETS), "busy length");
      check(r_sel, exp_sel, "remote flags");
      check(c_sel, exp_sel, "central flags");
      check(r_dft, dft, "transform size");
      check(c_pts, 16'(int'(dft) * 256), "transform points");
      check(r_ce, ce, "remote extension");
      check(c_ce, ce, "central extension");
      check(r_fbo, c_fb, "frame bits");
      // Differential bit: repeated octets cancel, flag bit 0 remains
      check(dpsk, c_cap[0] ^ exp_sel[0], "dpsk bit");
      net_start = 1'b1;
      step();
      net_start = 1'b0;
      step();
      check(training, 1'b1, "start outside silent");
      los = t[0];
      ierr = !t[0];
      step();
      los = 1'b0;
      ierr = 1'b0;
      step();
      check(silent, 1'b1, "silent after fault");
      // Restart while the remote is done: first octet must stand
      net_start = 1'b1;
      step();
      net_start = 1'b0;
      repeat (3) step();
      check(link.c2r_valid, 1'b1, "octet withdrawn");
      check(link.c2r_octet, {c_fb, L1_LINE_MODE[5:0]}, "held level-1 octet");
      $display("test %0d done", t);
    end
    finish_test();
  end
endmodule : testbench
